/* design/tbs_params.svh */
// constants for the tdm backplane slot interface
// Summary of operation
// - bus is sixteen bits, 128 slots
// - channel is two words, 24-bit sample
// - standard card base from backplane position
// - drive bus only in own slots
// - multichannel card base from on-card switches
// - other cards span exactly four channels
// - output card: bus in bus mode, else local
// - input card writes only in bus mode
// - per-position jumper can cut mode line
// - sync from bus line or reference input
// - default channel order kept unchanged
// - commands set arbitrary channel mapping
`ifndef TBS_PARAMS_SVH
`define TBS_PARAMS_SVH
`define TBS_WORD_W      16
`define TBS_SLOT_W      7
`define TBS_CHAN_W      6
`define TBS_CHANS       64
`define TBS_CARD_CHANS  6'h04
`define TBS_MULTI_CHANS 6'h08
`define TBS_FIFO_DEPTH  4
`define TBS_SLOT_FIRST  7'h00
`endif

/* design/tbs_pkg.sv */
// types shared by the tdm backplane slot interface
`include "tbs_params.svh"
package tbs_pkg;
   // one audio channel as it travels through the card
   typedef struct packed {
      logic [5:0]  chan;
      logic [23:0] audio;
      logic        user;
      logic        status;
   } tbs_sample_t;
   // static card straps: position, switches, card type, sync jumper
   typedef struct packed {
      logic [3:0] cardAddr;
      logic [5:0] dipAddr;
      logic       multiChan;
      logic       isOutput;
      logic       syncFromRef;
   } tbs_strap_t;
   // backplane pins that arrive from outside the clock domain
   typedef struct packed {
      logic        slotClk;
      logic        frame;
      logic        sync;
      logic        modeSel;
      logic        jumperFit;
      logic        syncRef;
      logic [15:0] data;
   } tbs_pins_t;
   // bus driver phase within one owned channel
   typedef enum logic [1:0] {
      TBS_QUIET    = 2'b00,
      TBS_DRIVE_HI = 2'b01,
      TBS_DRIVE_LO = 2'b10
   } tbs_drive_t;
   // true when the channel lies in the card's own window
   function automatic logic tbs_owns(input logic [5:0] chan, input tbs_strap_t s);
      logic [5:0] base;
      logic [5:0] span;
      base = s.multiChan ? s.dipAddr : {s.cardAddr, 2'b00};
      span = s.multiChan ? `TBS_MULTI_CHANS : `TBS_CARD_CHANS;
      return (chan >= base) && (6'(chan - base) < span);
   endfunction
endpackage

/* design/tbs_slot_interface.sv */
// tdm backplane slot interface of one plug-in card, with its sample fifo
`timescale 1ns/1ps
`include "tbs_params.svh"

module tbs_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = `TBS_FIFO_DEPTH
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic             wrValid,
   input  wire logic [WIDTH-1:0] wrData,
   output logic                  wrReady,
   output logic                  rdValid,
   output logic      [WIDTH-1:0] rdData,
   input  wire logic             rdReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];   // storage, depth must be a power of two
   logic [AW-1:0]    wrPtr;         // next slot to fill
   logic [AW-1:0]    rdPtr;         // oldest word
   logic [AW:0]      count;         // words held
   logic [AW-1:0]    next_wrPtr;
   logic [AW-1:0]    next_rdPtr;
   logic [AW:0]      next_count;
   logic             next_wrReady;
   logic             next_rdValid;
   logic             push;
   logic             pop;

   // flags are registered from the next count so both sides see honest levels
   always_comb begin
      push         = wrValid & wrReady;
      pop          = rdValid & rdReady;
      next_wrPtr   = push ? AW'(wrPtr + 1'b1) : wrPtr;
      next_rdPtr   = pop ? AW'(rdPtr + 1'b1) : rdPtr;
      next_count   = (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      next_wrReady = next_count != (AW+1)'(DEPTH);
      next_rdValid = next_count != '0;
   end

   // register pointers and flags
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wrPtr   <= '0;
         rdPtr   <= '0;
         count   <= '0;
         wrReady <= 1'b0;
         rdValid <= 1'b0;
      end else begin
         wrPtr   <= next_wrPtr;
         rdPtr   <= next_rdPtr;
         count   <= next_count;
         wrReady <= next_wrReady;
         rdValid <= next_rdValid;
      end
   end

   // storage needs no reset
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wrPtr] <= wrData;
      end
   end

   assign rdData = mem[rdPtr];
endmodule // tbs_fifo

module tbs_slot_interface
   import tbs_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire tbs_strap_t  strap,
   input  wire logic        busSlotClock,
   input  wire logic        busFrame,
   input  wire logic        busSync,
   input  wire logic        busModeSel,
   input  wire logic        modeJumperFit,
   input  wire logic        syncRefIn,
   input  wire logic [15:0] busDataIn,
   input  wire tbs_sample_t inSample,
   input  wire logic        inValid,
   output logic             inReady,
   input  wire logic        mapWrite,
   input  wire logic [5:0]  mapBusChan,
   input  wire logic [5:0]  mapStreamChan,
   output tbs_sample_t      outSample,
   output logic             outValid,
   input  wire logic        outReady,
   output logic [15:0]      busDataOut,
   output logic             busDataOe,
   output logic             syncOut,
   output logic             busModeActive
);
   tbs_pins_t   pinA;              // first synchroniser stage, read only by pinB
   tbs_pins_t   pinB;              // second stage, safe to use
   tbs_strap_t  strapA;            // straps are pins too
   tbs_strap_t  strapB;
   logic        clkPrev;           // last slot clock level, for edge finding
   logic [6:0]  slot;              // current slot number
   logic [15:0] hiWord;            // upper word held until its partner slot
   tbs_drive_t  drvState;          // driver phase
   logic [5:0]  chanMap [`TBS_CHANS]; // bus channel to stream channel
   logic        mapTouched;        // any map write since reset
   logic        slotEdge;
   logic        busMode;
   logic [6:0]  next_slot;
   logic [15:0] next_hiWord;
   tbs_drive_t  next_drvState;
   logic [15:0] next_busDataOut;
   logic        next_busDataOe;
   logic        next_syncOut;
   tbs_sample_t next_outSample;
   logic        next_outValid;
   logic        fifoWrValid;
   tbs_sample_t fifoWrData;
   logic        fifoWrReady;
   logic        fifoRdValid;
   tbs_sample_t fifoRdData;
   logic        fifoRdReady;
   logic        capture;           // bus word pair completes into the fifo

   // two flip-flops on every outside input
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pinA   <= '0;
         pinB   <= '0;
         strapA <= '0;
         strapB <= '0;
      end else begin
         pinA   <= {busSlotClock, busFrame, busSync, busModeSel, modeJumperFit,
                    syncRefIn, busDataIn};
         pinB   <= pinA;
         strapA <= strap;
         strapB <= strapA;
      end
   end

   // a missing jumper leaves the select low, which reads as standalone
   assign busMode  = pinB.modeSel & pinB.jumperFit;
   assign slotEdge = pinB.slotClk & ~clkPrev;
   // bus words complete a pair on the closing edge of an owned odd slot
   assign capture  = slotEdge & busMode & strapB.isOutput & slot[0]
                     & tbs_owns(slot[6:1], strapB);

   // fifo source: bus pairs for an output card in bus mode, else local input
   always_comb begin
      fifoWrData = inSample;
      fifoWrValid = 1'b0;
      if (strapB.isOutput & busMode) begin
         fifoWrValid = capture;
         fifoWrData  = {chanMap[slot[6:1]], hiWord, pinB.data[15:8],
                        pinB.data[7], pinB.data[6]};
      end else begin
         fifoWrValid = inValid;
      end
   end

   // slot counting, bus driver and sync selection
   always_comb begin
      next_slot       = slot;
      next_hiWord     = hiWord;
      next_drvState   = drvState;
      next_busDataOut = busDataOut;
      next_busDataOe  = busDataOe;
      next_syncOut    = strapB.syncFromRef ? pinB.syncRef : pinB.sync;
      fifoRdReady     = 1'b0;
      if (slotEdge) begin
         // frame marks slot zero; 128 slots wrap naturally
         next_slot = pinB.frame ? `TBS_SLOT_FIRST : 7'(slot + 1'b1);
         if (strapB.isOutput & ~slot[0]) begin
            next_hiWord = pinB.data;
         end
         next_drvState  = TBS_QUIET;
         next_busDataOe = 1'b0;
         next_busDataOut = 16'h0000;
         // only an input card in bus mode writes, and only its own slots
         if (busMode & ~strapB.isOutput & tbs_owns(next_slot[6:1], strapB)) begin
            next_busDataOe = 1'b1;
            if (~next_slot[0]) begin
               next_drvState   = fifoRdValid ? TBS_DRIVE_HI : TBS_QUIET;
               next_busDataOut = fifoRdValid ? fifoRdData.audio[23:8] : 16'h0000;
            end else if (drvState == TBS_DRIVE_HI) begin
               next_drvState   = TBS_DRIVE_LO;
               // pop as the lower word is loaded, so the next even slot sees the next pair
               fifoRdReady     = 1'b1;
               next_busDataOut = {fifoRdData.audio[7:0], fifoRdData.user,
                                  fifoRdData.status, 6'h00};
            end
         end
      end
      if (strapB.isOutput) begin
         fifoRdReady = ~outValid | outReady;
      end
      next_outSample = outSample;
      next_outValid  = outValid & ~outReady;
      if (strapB.isOutput & fifoRdValid & fifoRdReady) begin
         next_outSample = fifoRdData;
         next_outValid  = 1'b1;
      end
   end

   // register slot state and outputs
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         clkPrev       <= 1'b0;
         slot          <= `TBS_SLOT_FIRST;
         hiWord        <= 16'h0000;
         drvState      <= TBS_QUIET;
         busDataOut    <= 16'h0000;
         busDataOe     <= 1'b0;
         syncOut       <= 1'b0;
         outSample     <= '0;
         outValid      <= 1'b0;
         busModeActive <= 1'b0;
      end else begin
         clkPrev       <= pinB.slotClk;
         slot          <= next_slot;
         hiWord        <= next_hiWord;
         drvState      <= next_drvState;
         busDataOut    <= next_busDataOut;
         busDataOe     <= next_busDataOe;
         syncOut       <= next_syncOut;
         outSample     <= next_outSample;
         outValid      <= next_outValid;
         busModeActive <= busMode;
      end
   end

   // channel map: identity after reset, rewritten by commands
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mapTouched <= 1'b0;
         for (int i = 0; i < `TBS_CHANS; i++) begin
            chanMap[i] <= 6'(i);
         end
      end else begin
         mapTouched <= mapTouched | mapWrite;
         if (mapWrite) begin
            chanMap[mapBusChan] <= mapStreamChan;
         end
      end
   end

   tbs_fifo #(
      .WIDTH ($bits(tbs_sample_t)),
      .DEPTH (`TBS_FIFO_DEPTH)
   ) u_fifo (
      .clock   (clock),
      .sys_rst (sys_rst),
      .wrValid (fifoWrValid),
      .wrData  (fifoWrData),
      .wrReady (fifoWrReady),
      .rdValid (fifoRdValid),
      .rdData  (fifoRdData),
      .rdReady (fifoRdReady)
   );

   // ready comes straight from the fifo flag; when full, bus pairs are lost
   assign inReady = fifoWrReady;

   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence sLowWordOut;
      slotEdge && drvState == TBS_DRIVE_HI && busDataOe;
   endsequence
   sequence sPairClosed;
      slotEdge && drvState == TBS_DRIVE_LO;
   endsequence

   chk_drive_own_slot: assert property (busDataOe |-> tbs_owns(slot[6:1], strapB))
      else $error("bus driven outside own slots");
   chk_standalone_quiet: assert property (slotEdge && !busMode |=> !busDataOe)
      else $error("bus driven while standalone");
   chk_output_never_drives: assert property (strapB.isOutput && slotEdge |=> !busDataOe)
      else $error("output card drove the bus");
   chk_addr_zero_start: assert property (slotEdge && busMode && !strapB.isOutput
      && !strapB.multiChan && strapB.cardAddr == 4'h0 && next_slot < 7'h08
      |=> busDataOe)
      else $error("address zero card missed its slot");
   chk_four_chan_span: assert property (busDataOe && !strapB.multiChan
      |-> 6'(slot[6:1] - {strapB.cardAddr, 2'b00}) < 6'h04)
      else $error("standard card beyond four channels");
   chk_switch_base: assert property (busDataOe && strapB.multiChan
      |-> slot[6:1] >= strapB.dipAddr)
      else $error("multichannel card below switch base");
   chk_pair_order: assert property (sLowWordOut |-> fifoRdReady ##1 (drvState == TBS_DRIVE_LO)
      ##[1:40] sPairClosed)
      else $error("word pair not closed in order");
   chk_sync_pick: assert property (##1 syncOut
      == $past(strapB.syncFromRef ? pinB.syncRef : pinB.sync))
      else $error("sync source not per jumper");
   chk_map_identity: assert property (capture && !mapTouched
      |-> fifoWrData.chan == slot[6:1])
      else $error("default channel order changed");
   chk_map_write: assert property (mapWrite |=> chanMap[$past(mapBusChan)]
      == $past(mapStreamChan))
      else $error("channel map write lost");
   chk_bus_source: assert property (busMode && strapB.isOutput && fifoWrValid
      |-> capture)
      else $error("output card took local audio in bus mode");
endmodule // tbs_slot_interface

/* verification/tb_top.sv */
// self-checking bench of the slot interface against a queue model
`timescale 1ns/1ps
module tb_top
   import tbs_pkg::*;
;
   logic        clock, sys_rst, inValid, inReady, mapWrite, outValid, outReady;
   logic        busDataOe, syncOut, busModeActive, busSlotClock, busFrame, busSync;
   logic        busModeSel, modeReq, drvEn, jumper, syncRefIn, pm;
   tbs_strap_t  strap;
   tbs_sample_t inSample, outSample, e;
   logic [5:0]  mapBusChan, mapStreamChan, selHist;
   logic [15:0] busDataOut, mdlData, busWire, expW, lo, hiWord;
   logic [5:0]  chanMap [64];   // expected channel map
   tbs_sample_t inQ[$], outQ[$]; // expected bus words / stream samples
   int          errCount, nChecks, cycles, slotNow, stChg;
   // one wire: the card when enabled, otherwise the rest of the rack
   assign busWire = busDataOe ? busDataOut : mdlData;
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   tbs_slot_interface tbs_slot_interface_inst (.clock(clock), .sys_rst(sys_rst), .strap(strap),
      .busSlotClock(busSlotClock), .busFrame(busFrame), .busSync(busSync),
      .busModeSel(busModeSel), .modeJumperFit(jumper), .syncRefIn(syncRefIn),
      .busDataIn(busWire), .inSample(inSample), .inValid(inValid), .inReady(inReady),
      .mapWrite(mapWrite), .mapBusChan(mapBusChan), .mapStreamChan(mapStreamChan),
      .outSample(outSample), .outValid(outValid), .outReady(outReady),
      .busDataOut(busDataOut), .busDataOe(busDataOe), .syncOut(syncOut),
      .busModeActive(busModeActive));
   tbs_bus_master tbs_bus_master_inst (.modeReq(modeReq), .drvEn(drvEn),
      .busSlotClock(busSlotClock), .busFrame(busFrame), .busSync(busSync),
      .busModeSel(busModeSel), .busData(mdlData));
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      nChecks++;
      if (got !== exp) begin
         errCount++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   function automatic tbs_strap_t mk(input int a, input int d, input logic m, input logic o,
                                     input logic r);
      return {4'(a), 6'(d), m, o, r};
   endfunction
   function automatic logic owns(input int ch);
      int base;
      int span;
      base = strap.multiChan ? int'(strap.dipAddr) : 4 * int'(strap.cardAddr);
      span = strap.multiChan ? 8 : 4;
      return ch >= base && ch < base + span;
   endfunction
   // slot monitor: at each slot rise the outputs still show the slot just closed
   always @(posedge busSlotClock) begin
      #1;
      lo = {1'b0, 7'(slotNow), ~7'(slotNow), 1'b1};
      if (pm && owns(slotNow / 2) && !strap.isOutput) begin
         e    = inQ.size() > 0 ? inQ[0] : '0; // empty fifo sends zeros
         expW = slotNow[0] ? {e.audio[7:0], e.user, e.status, 6'h00} : e.audio[23:8];
         if (slotNow[0] && inQ.size() > 0) void'(inQ.pop_front());
         cmp("busDataOut", expW, busDataOut);
      end else if (pm && owns(slotNow / 2) && !slotNow[0]) hiWord = lo;
      else if (pm && owns(slotNow / 2)) begin
         outQ.push_back(tbs_sample_t'({chanMap[slotNow / 2], hiWord, lo[15:8], lo[7], lo[6]}));
      end
      cmp("busDataOe", pm && !strap.isOutput && owns(slotNow / 2), busDataOe);
      if (pm == (busModeSel & jumper)) cmp("busModeActive", pm, busModeActive);
      pm      = busModeSel & jumper;
      slotNow = busFrame ? 0 : slotNow + 1;
   end
   // timeout: about 19200 cycles are needed, a hang counts as a mismatch
   always @(posedge clock) begin
      cycles++;
      if (cycles > 24000) begin
         errCount++;
         conclude();
      end
   end
   // stream and sync watch on the system clock
   always @(posedge clock) begin
      stChg++;
      if (outValid === 1'b1 && outReady === 1'b1) begin
         if (outQ.size() == 0) cmp("outValid", 1'b0, outValid);
         else cmp("outSample", outQ.pop_front(), outSample);
      end
      selHist = {selHist[4:0], strap.syncFromRef ? syncRefIn : busSync};
      // compare only on a steady input so a one-cycle skew cannot matter
      if (stChg > 8 && selHist[5:2] inside {4'h0, 4'hf}) cmp("syncOut", selHist[3], syncOut);
   end
   // random stall of the far side and a slowly moving reference
   always @(posedge clock) begin
      #1;
      outReady = 1'($urandom_range(1, 0));
      if (cycles % 8 == 0) syncRefIn = 1'($urandom_range(1, 0));
   end
   task automatic atSlot(input int s);
      do begin
         @(posedge busSlotClock);
         #2;
      end while (slotNow != s);
      @(posedge clock);
      #1;
   endtask
   task automatic pushSamples(input int n);
      tbs_sample_t s;
      int t;
      for (int i = 0; i < n; i++) begin
         s        = tbs_sample_t'($urandom);
         inSample = s;
         inValid  = 1'b1;
         t        = 0;
         do begin
            @(posedge clock);
            t++;
         end while (inReady !== 1'b1 && t < 50);
         if (t >= 50) cmp("inReady", 1'b1, inReady);
         if (strap.isOutput) outQ.push_back(s);
         else inQ.push_back(s);
         #1;
      end
      inValid = 1'b0;
   endtask
   task automatic remap(input logic [5:0] c);
      mapBusChan    = c;
      mapStreamChan = 6'($urandom);
      mapWrite      = 1'b1;
      @(posedge clock);
      #1;
      mapWrite      = 1'b0;
      chanMap[c]    = mapStreamChan;
   endtask
   // new straps and mode late in a frame, then n frames of traffic
   task automatic phase(input tbs_strap_t st, input logic m, input logic j, input int n,
                        input int p);
      atSlot(100);
      strap   = st;
      modeReq = m;
      jumper  = j;
      drvEn   = st.isOutput;
      stChg   = 0;
      repeat (4) @(posedge clock);
      #1;
      // on an output card in bus mode the first frame runs on the identity map, later ones on a rewritten one
      repeat (n) begin
         if (p > 0) pushSamples($urandom_range(p, 2));
         atSlot(100);
         if (st.isOutput && m) remap(6'(4 * st.cardAddr + $urandom_range(3, 0)));
      end
   endtask
   initial begin
      void'($urandom(11923));
      {sys_rst, inValid, mapWrite, outReady, syncRefIn, modeReq, drvEn, pm} = 8'h80;
      {inSample, mapBusChan, mapStreamChan, selHist} = '0;
      jumper = 1'b1;
      strap  = '0;
      {errCount, nChecks, cycles, slotNow, stChg} = '0;
      for (int i = 0; i < 64; i++) chanMap[i] = 6'(i);
      repeat (10) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      phase(mk(0, 0, 0, 0, 0), 1'b1, 1'b1, 3, 4);
      phase(mk(5, 20, 1, 0, 1), 1'b1, 1'b1, 2, 4);
      phase(mk(2, 0, 0, 0, 1), 1'b1, 1'b0, 1, 0);
      phase(mk(2, 0, 0, 0, 0), 1'b0, 1'b1, 1, 0);
      phase(mk(2, 0, 0, 1, 0), 1'b0, 1'b1, 2, 4);
      phase(mk(3, 0, 0, 1, 1), 1'b1, 1'b1, 3, 0);
      atSlot(100);
      conclude();
   end
endmodule // tb_top

/* verification/tbs_bus_master.sv */
// bus master model: slot clock, frame, sync, mode line and the other cards' data
`timescale 1ns/1ps
module tbs_bus_master (
   input  wire logic        modeReq,
   input  wire logic        drvEn,
   output logic             busSlotClock,
   output logic             busFrame,
   output logic             busSync,
   output logic             busModeSel,
   output logic [15:0]      busData
);
   logic [6:0] slot; // slot begun at the last rise
   // the master owns the mode line for the whole rack
   assign busModeSel = modeReq;
   // free-running slot clock of eight system clocks; phase offset keeps its edges clear of the system clock edges
   initial begin
      busSlotClock = 1'b0;
      busFrame     = 1'b0;
      busSync      = 1'b0;
      busData      = 16'h0000;
      slot         = 7'h7f;
      #37;
      forever begin
         slot         = slot + 7'h01;
         busFrame     = (slot == 7'h00);
         busSync      = slot[3];
         busSlotClock = 1'b1;
         #80;
         busSlotClock = 1'b0;
         // data moves mid-slot so it is stable at the closing rise; a quiet bus toggles
         busData      = drvEn ? {1'b0, slot, ~slot, 1'b1} : ~busData;
         #80;
      end
   end
endmodule // tbs_bus_master
